// ===== usbc_engine_cfg.sv
/*
 usbc_engine_cfg.sv - configuration and control of the serial engine:
 APB register slave, frame count, line monitor, endpoint commands.
 Assumes APB master on pclk, engine strobes on pclk, line pins async.
*/
// What this block does
// - frame reset clears count bits 10-0, not extension; engine reset bit
// - extended enable widens frame count to 16
// - extension disabled: high bits 7-3 read zero
// - extension counts falls of high bit 2
// - suspend-force puts engine in suspend
// - resume-force drives resume signalling on line
// - resume seen in suspend: flag, interrupt
// - SE0 for 32 bit times: flag, interrupt
// - busy-on-setup marks enabled directions busy
// - without busy-on-setup, setup changes nothing
// - iso limit code selects packet size
// - nonzero codes include eight-byte header
// - command write changes one endpoint field
// - command bit 7 selects transmit or receive
// - command codes: modes, toggle, iso
`default_nettype none
`include "usbc_consts.svh"

module usbc_engine_cfg
	import usbc_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        pclken,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [17:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        dp_in,
	input  wire logic        dm_in,
	output logic             dp_out,
	output logic             dp_oe,
	output logic             dm_out,
	output logic             dm_oe,
	input  wire logic        sof_valid,
	input  wire logic [10:0] sof_frame,
	input  wire logic        setup_rx,
	input  wire logic [3:0]  setup_ep,
	output logic             full_speed_enable,
	output logic             engine_reset,
	output logic             engine_suspend,
	output usbc_iso_t        iso_limit,
	output logic             irq
);

	localparam int SE0_CYC = `USBC_SE0_CYC;
	localparam logic [6:0] SE0_LIM = 7'(SE0_CYC);

	if (SE0_CYC < 1 || SE0_CYC > 127) begin : g_chk
		$error("usbc_engine_cfg: bus reset count does not fit");
	end

	usbc_state_t   r;
	usbc_state_t   n;
	usbc_mem_req_t mreq;
	logic [7:0]    mrd;
	logic [15:0]   idx;
	logic          acc;
	logic          slow;
	logic          se0;
	logic          kstate;
	logic          busrst;
	logic          brst_ev;
	logic          rsm_ev;
	logic          wr_fast;
	logic          wr_cfg;

	// true for an aligned address that holds a register
	function automatic logic mapped(input logic [17:0] a);
		logic [15:0] i;
		i = a[17:2];
		mapped = (a[1:0] == `USBC_ALIGN) &&
			(i == `USBC_IDX_CFG || i == `USBC_IDX_CTL2 ||
			 i == `USBC_IDX_CMD || i == `USBC_IDX_FRL ||
			 i == `USBC_IDX_FRH || i == `USBC_IDX_IST ||
			 i == `USBC_IDX_ICL || i == `USBC_IDX_IEN ||
			 i == `USBC_IDX_EPS || i == `USBC_IDX_EPV);
	endfunction

	// read value of every register that answers without the memory
	function automatic logic [7:0] read_reg(input logic [15:0] i,
			input usbc_state_t s, input logic brst);
		case (i)
			`USBC_IDX_CFG: read_reg = {s.cfg[7:`USBC_CFG_WLO],
				s.resume_seen, brst};
			`USBC_IDX_CTL2: read_reg = s.ctl2;
			`USBC_IDX_CMD: read_reg = s.cmd;
			`USBC_IDX_FRL: read_reg = s.frame[7:0];
			`USBC_IDX_FRH: read_reg = {s.frame_ext, s.frame[10:8]};
			`USBC_IDX_IST: read_reg = {6'h00, s.irq_stat};
			`USBC_IDX_IEN: read_reg = {6'h00, s.irq_en};
			`USBC_IDX_EPS: read_reg = {4'h0, s.ep_sel};
			default: read_reg = 8'h00;
		endcase
	endfunction

	// one endpoint command applied to one direction nibble
	function automatic logic [3:0] cmd_nib(input logic [3:0] nib,
			input logic [2:0] c);
		cmd_nib = nib;
		if (!c[2]) begin
			cmd_nib[1:0] = c[1:0];
		end else if (!c[1]) begin
			cmd_nib[`USBC_EPF_TOG] = c[0];
		end else begin
			cmd_nib[`USBC_EPF_ISO] = c[0];
		end
	endfunction

	// command applied to the half picked by the direction bit
	function automatic logic [7:0] apply_cmd(input logic [7:0] cur,
			input logic [7:0] cmd);
		logic [2:0] c;
		c = cmd[`USBC_CMD_HI:`USBC_CMD_LO];
		apply_cmd = cur;
		if (cmd[`USBC_CMD_DIR]) begin
			apply_cmd[7:4] = cmd_nib(cur[7:4], c);
		end else begin
			apply_cmd[3:0] = cmd_nib(cur[3:0], c);
		end
	endfunction

	// a direction that is not disabled becomes busy
	function automatic logic [3:0] busy_nib(input logic [3:0] nib);
		busy_nib = nib;
		if (nib[1:0] != `USBC_MODE_OFF) begin
			busy_nib[1:0] = `USBC_MODE_NAK;
		end
	endfunction

	// isochronous size from the limit code
	function automatic usbc_iso_t iso_of(input logic [1:0] code);
		usbc_iso_t v;
		case (code)
			2'h0: v.total = `USBC_ISO_FULL;
			2'h2: v.total = `USBC_ISO_MID;
			default: v.total = `USBC_ISO_SMALL;
		endcase
		v.data = v.total - ((code == 2'h0) ?
			`USBC_ISO_NOHDR : `USBC_ISO_HDR);
		iso_of = v;
	endfunction

	// decode of the bus request
	assign idx     = paddr[17:2];
	assign acc     = psel && penable;
	assign slow    = mapped(paddr) && ((pwrite && idx == `USBC_IDX_CMD) ||
		(!pwrite && idx == `USBC_IDX_EPV));
	assign pready  = !slow || (r.phase == PH_DONE);
	assign pslverr = acc && !mapped(paddr);
	assign wr_fast = acc && pwrite && !slow && mapped(paddr);
	assign wr_cfg  = wr_fast && (idx == `USBC_IDX_CFG);

	// line state from the second synchroniser stage only
	assign se0    = !r.dp_sync[1] && !r.dm_sync[1];
	assign kstate = !r.dp_sync[1] && r.dm_sync[1];
	assign busrst = (r.se0_cnt == SE0_LIM);
	assign brst_ev = se0 && (r.se0_cnt == SE0_LIM - 7'h01);
	assign rsm_ev = kstate && r.cfg[`USBC_CFG_SUSP] &&
		!r.cfg[`USBC_CFG_RSM] && !r.resume_seen;

	usbc_ep_mem #(
		.WIDTH (8),
		.DEPTH (16)
	) u_mem (
		.pclk    (pclk),
		.presetn (presetn),
		.pclken  (pclken),
		.we      (mreq.we),
		.addr    (mreq.addr),
		.wdata   (mreq.wdata),
		.rdata   (mrd)
	);

	// next state of the whole block
	always_comb begin
		n    = r;
		mreq = '0;

		// two-stage synchronisers for the line pins
		n.dp_sync = {r.dp_sync[0], dp_in};
		n.dm_sync = {r.dm_sync[0], dm_in};

		// SE0 duration, saturating at the bus reset count
		if (!se0) begin
			n.se0_cnt = 7'h00;
		end else if (!busrst) begin
			n.se0_cnt = r.se0_cnt + 7'h01;
		end

		// resume seen while suspended, held until suspend is left
		if (rsm_ev) begin
			n.resume_seen = 1'b1;
		end else if (!r.cfg[`USBC_CFG_SUSP]) begin
			n.resume_seen = 1'b0;
		end

		// frame count from the engine, extension on falls of bit 10
		if (sof_valid) begin
			n.frame = sof_frame;
			if (r.cfg[`USBC_CFG_EXT] && r.frame[`USBC_FR_TOP] &&
					!sof_frame[`USBC_FR_TOP]) begin
				n.frame_ext = r.frame_ext + 5'h01;
			end
		end
		if (r.cfg[`USBC_CFG_FRST]) begin
			n.frame = 11'h000;
		end
		if (!r.cfg[`USBC_CFG_EXT]) begin
			n.frame_ext = 5'h00;
		end

		// read data of fast registers taken in the setup cycle
		if (psel && !penable && !pwrite) begin
			n.prdata = {24'h000000, read_reg(idx, r, busrst)};
		end

		// plain register writes
		if (wr_fast) begin
			case (idx)
				`USBC_IDX_CFG: n.cfg[7:`USBC_CFG_WLO] =
					pwdata[7:`USBC_CFG_WLO];
				`USBC_IDX_CTL2: n.ctl2 = pwdata[7:0];
				`USBC_IDX_ICL: n.irq_stat = r.irq_stat & ~pwdata[1:0];
				`USBC_IDX_IEN: n.irq_en = pwdata[1:0];
				`USBC_IDX_EPS: n.ep_sel = pwdata[3:0];
				default: n.ep_sel = r.ep_sel;
			endcase
		end

		// events set status after any clear, so set wins
		if (rsm_ev) begin
			n.irq_stat[`USBC_IRQ_RSM] = 1'b1;
		end
		if (brst_ev) begin
			n.irq_stat[`USBC_IRQ_BRST] = 1'b1;
		end

		// endpoint memory sequencer
		case (r.phase)
			PH_IDLE: begin
				if (acc && slow) begin
					mreq.addr = pwrite ? pwdata[3:0] : r.ep_sel;
					n.phase   = PH_FETCH;
				end else if (r.pend_setup) begin
					mreq.addr    = r.pend_ep;
					n.work_ep    = r.pend_ep;
					n.pend_setup = 1'b0;
					n.phase      = PH_SETUP;
				end
			end
			PH_FETCH: begin
				if (pwrite) begin
					mreq.we    = 1'b1;
					mreq.addr  = pwdata[3:0];
					mreq.wdata = apply_cmd(mrd, pwdata[7:0]);
					n.cmd      = pwdata[7:0];
				end else begin
					n.prdata = {24'h000000, mrd};
				end
				n.phase = PH_DONE;
			end
			PH_DONE: begin
				n.phase = PH_IDLE;
			end
			PH_SETUP: begin
				if (r.ctl2[`USBC_CTL2_BOS]) begin
					mreq.we    = 1'b1;
					mreq.addr  = r.work_ep;
					mreq.wdata = {busy_nib(mrd[7:4]), busy_nib(mrd[3:0])};
				end
				n.phase = PH_IDLE;
			end
			default: begin
				n.phase = PH_IDLE;
			end
		endcase

		// setup from the engine waits its turn; set wins over take
		if (setup_rx) begin
			n.pend_setup = 1'b1;
			n.pend_ep    = setup_ep;
		end
	end

	// state register, frozen while the clock enable is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r     <= '0;
			r.cfg <= `USBC_CFG_RST;
			r.ctl2 <= `USBC_CTL2_RST;
		end else if (pclken) begin
			r <= n;
		end
	end

	// outputs straight from state
	assign prdata            = r.prdata;
	assign full_speed_enable = r.cfg[`USBC_CFG_FULL_SPEED_ENABLE];
	assign engine_reset      = r.cfg[`USBC_CFG_ERST];
	assign engine_suspend    = r.cfg[`USBC_CFG_SUSP];
	assign dp_out            = 1'b0;
	assign dm_out            = r.cfg[`USBC_CFG_RSM];
	assign dp_oe             = r.cfg[`USBC_CFG_RSM];
	assign dm_oe             = r.cfg[`USBC_CFG_RSM];
	assign iso_limit         = iso_of(r.ctl2[1:0]);
	assign irq               = |(r.irq_stat & r.irq_en);

	// checks on enabled edges only
	default clocking cb @(posedge pclk iff pclken);
	endclocking
	default disable iff (!presetn);

	// frame count held at zero while frame reset is set
	chk_frame_clear: assert property (
		r.cfg[`USBC_CFG_FRST] |=> (r.frame == 11'h000))
		else $error("frame count not cleared by frame reset");

	// extension bits read zero while disabled
	chk_ext_zero: assert property (
		!r.cfg[`USBC_CFG_EXT] |=>
		(read_reg(`USBC_IDX_FRH, r, busrst) & 8'hF8) == 8'h00)
		else $error("high frame bits not zero");

	// extension steps once on a fall of bit 10
	chk_ext_count: assert property (
		(r.cfg[`USBC_CFG_EXT] && !r.cfg[`USBC_CFG_FRST] && sof_valid &&
		 r.frame[`USBC_FR_TOP] && !sof_frame[`USBC_FR_TOP]) |=>
		(r.frame_ext == $past(r.frame_ext) + 5'h01))
		else $error("frame extension did not step");

	// suspend follows a write of the suspend bit
	chk_suspend_set: assert property (
		(wr_cfg && pwdata[`USBC_CFG_SUSP]) |=> engine_suspend)
		else $error("suspend not entered");

	// resume write drives K on both lines
	chk_resume_drive: assert property (
		(wr_cfg && pwdata[`USBC_CFG_RSM]) |=>
		(dp_oe && dm_oe && dm_out && !dp_out))
		else $error("resume signalling not driven");

	// resume flag drops when suspend is left
	chk_resume_flag: assert property (
		!r.cfg[`USBC_CFG_SUSP] |=> !r.resume_seen)
		else $error("resume flag outside suspend");

	// bus reset flag only after the line stayed SE0
	chk_bus_reset: assert property (
		$rose(busrst) |-> ($past(se0) && $past(r.se0_cnt) == SE0_LIM - 7'h01))
		else $error("bus reset without long SE0");

	// enabled bus reset event raises the interrupt next cycle
	chk_reset_irq: assert property (
		(brst_ev && r.irq_en[`USBC_IRQ_BRST]) |=> irq)
		else $error("bus reset interrupt missing");

	// setup with busy-on-setup writes a busy word
	chk_setup_busy: assert property (
		(r.phase == PH_SETUP && r.ctl2[`USBC_CTL2_BOS] &&
		 mrd[1:0] != `USBC_MODE_OFF) |->
		(mreq.we && mreq.wdata[1:0] == `USBC_MODE_NAK))
		else $error("setup did not mark endpoint busy");

	// setup without busy-on-setup leaves the memory alone
	chk_setup_quiet: assert property (
		(r.phase == PH_SETUP && !r.ctl2[`USBC_CTL2_BOS]) |-> !mreq.we)
		else $error("setup changed endpoint without busy-on-setup");

	// mid iso code gives 504 total and 496 data
	chk_iso_mid: assert property (
		(r.ctl2[1:0] == 2'h2) |->
		(iso_limit.total == 11'h1F8 && iso_limit.data == 11'h1F0))
		else $error("iso limit wrong");

	// command write reaches memory one cycle into the access
	chk_cmd_write: assert property (
		(acc && slow && pwrite && r.phase == PH_IDLE) |=>
		(mreq.we && mreq.addr == $past(pwdata[3:0])) ##1 pready)
		else $error("endpoint command not applied");

endmodule // usbc_engine_cfg

`default_nettype wire

// ===== usbc_consts.svh
/*
 usbc_consts.svh - register indices, field positions, reset values and
 timing figures of the serial engine configuration block.
 Assumes inclusion by bare name from the top module and the bench.
*/
`ifndef USBC_CONSTS_SVH
`define USBC_CONSTS_SVH

// register indices; byte address on the bus is index * 4
`define USBC_IDX_CFG   16'h7F98
`define USBC_IDX_CTL2  16'h7FA9
`define USBC_IDX_CMD   16'h7FAA
`define USBC_IDX_FRL   16'h7FB0
`define USBC_IDX_FRH   16'h7FB1
`define USBC_IDX_IST   16'h7FB2
`define USBC_IDX_ICL   16'h7FB3
`define USBC_IDX_IEN   16'h7FB4
`define USBC_IDX_EPS   16'h7FB5
`define USBC_IDX_EPV   16'h7FB6
`define USBC_ALIGN     2'h0

// reset values
`define USBC_CFG_RST   8'h40
`define USBC_CTL2_RST  8'h00

// configuration register bits
`define USBC_CFG_FULL_SPEED_ENABLE  7
`define USBC_CFG_ERST  6
`define USBC_CFG_FRST  5
`define USBC_CFG_EXT   4
`define USBC_CFG_SUSP  3
`define USBC_CFG_RSM   2
`define USBC_CFG_RSMD  1
`define USBC_CFG_BRST  0
`define USBC_CFG_WLO   2

// control register 2 bits
`define USBC_CTL2_BOS  2

// frame count: bit 2 of the high byte is bit 10 of the count
`define USBC_FR_TOP    10

// interrupt status bits
`define USBC_IRQ_RSM   0
`define USBC_IRQ_BRST  1

// endpoint control nibble: [1:0] handshake mode, [2] toggle, [3] iso
`define USBC_EPF_TOG   2
`define USBC_EPF_ISO   3
`define USBC_MODE_OFF  2'h0
`define USBC_MODE_NAK  2'h3

// endpoint command fields
`define USBC_CMD_DIR   7
`define USBC_CMD_HI    6
`define USBC_CMD_LO    4

// isochronous limits in bytes
`define USBC_ISO_FULL  11'h3FF
`define USBC_ISO_SMALL 11'h0F8
`define USBC_ISO_MID   11'h1F8
`define USBC_ISO_HDR   11'h008
`define USBC_ISO_NOHDR 11'h000

// bus reset: least time of 32 full-speed bit times, rounded up
`define USBC_SE0_BITS  32
`define USBC_FS_KHZ    12000
`define USBC_PCLK_KHZ  20000
`define USBC_SE0_CYC \
	((`USBC_SE0_BITS * `USBC_PCLK_KHZ + `USBC_FS_KHZ - 1) / `USBC_FS_KHZ)

`endif

// ===== usbc_pkg.sv
/*
 usbc_pkg.sv - types of the serial engine configuration block.
 Assumes usbc_consts.svh is on the include path.
*/
`default_nettype none

package usbc_pkg;

	// sequencer for accesses that go through the endpoint memory
	typedef enum logic [1:0] {
		PH_IDLE,
		PH_FETCH,
		PH_DONE,
		PH_SETUP
	} usbc_phase_t;

	// whole state of the top module
	typedef struct packed {
		logic [7:0]  cfg;
		logic [7:0]  ctl2;
		logic [7:0]  cmd;
		logic [10:0] frame;
		logic [4:0]  frame_ext;
		logic [1:0]  irq_stat;
		logic [1:0]  irq_en;
		logic        resume_seen;
		logic [6:0]  se0_cnt;
		logic [1:0]  dp_sync;
		logic [1:0]  dm_sync;
		logic        pend_setup;
		logic [3:0]  pend_ep;
		logic [3:0]  work_ep;
		logic [3:0]  ep_sel;
		usbc_phase_t phase;
		logic [31:0] prdata;
	} usbc_state_t;

	// endpoint memory request
	typedef struct packed {
		logic       we;
		logic [3:0] addr;
		logic [7:0] wdata;
	} usbc_mem_req_t;

	// isochronous packet limit
	typedef struct packed {
		logic [10:0] total;
		logic [10:0] data;
	} usbc_iso_t;

endpackage

`default_nettype wire

// ===== usbc_ep_mem.sv
/*
 usbc_ep_mem.sv - endpoint control store, one word per endpoint,
 registered read data, one port. Assumes a single clock with enable.
*/
`default_nettype none

module usbc_ep_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     pclken,
	input  wire logic                     we,
	input  wire logic [$clog2(DEPTH)-1:0] addr,
	input  wire logic [WIDTH-1:0]         wdata,
	output logic      [WIDTH-1:0]         rdata
);

	if (DEPTH < 2 || WIDTH < 1) begin : g_chk
		$error("usbc_ep_mem: bad geometry");
	end

	logic [DEPTH-1:0][WIDTH-1:0] mem;

	// reset leaves every endpoint disabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem   <= '0;
			rdata <= '0;
		end else if (pclken) begin
			if (we) begin
				mem[addr] <= wdata;
			end
			rdata <= mem[addr];
		end
	end

endmodule // usbc_ep_mem

`default_nettype wire

// ===== usbc_line_host.sv
/*
 usbc_line_host.sv - upstream host model on the full-speed line pins.
 Assumes the bench picks the line state; resolves the wire with the
 device's own drivers so that both parties see one level.
*/
`default_nettype none

module usbc_line_host (
	input  wire logic [1:0] mode,
	input  wire logic       dp_out,
	input  wire logic       dp_oe,
	input  wire logic       dm_out,
	input  wire logic       dm_oe,
	output logic            dp_line,
	output logic            dm_line
);
	timeunit 1ns;
	timeprecision 1ps;

	logic host_dp;
	logic host_dm;

	// host line state: 0 idle J, 1 single-ended zero, 2 K
	always_comb begin
		host_dp = (mode == 2'h0);
		host_dm = (mode == 2'h2);
	end

	// device drivers win while enabled, e.g. during forced resume
	assign dp_line = dp_oe ? dp_out : host_dp;
	assign dm_line = dm_oe ? dm_out : host_dm;

endmodule // usbc_line_host

`default_nettype wire

// ===== usbc_engine_cfg_bench.sv
/*
 usbc_engine_cfg_bench.sv - self-checking bench of the engine configuration block.
 Assumes the package, the constants header and the line host model are compiled first.
*/
`default_nettype none
`include "usbc_consts.svh"

module usbc_engine_cfg_bench
	import usbc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        pclk = 1'b0;
	logic        presetn, psel, penable, pwrite, sof_valid, setup_rx;
	logic [17:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	logic [10:0] sof_frame;
	logic [3:0]  setup_ep;
	logic [1:0]  line_mode;
	logic        pready, pslverr, dp_out, dp_oe, dm_out, dm_oe, dp_line, dm_line;
	logic        fse, ers, esus, irq, errv;
	usbc_iso_t   iso_limit;
	logic [7:0]  ep_v;
	int          num_errors, num_checks;

	usbc_engine_cfg dut_u (.pclk(pclk), .presetn(presetn), .pclken(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .dp_in(dp_line),
		.dm_in(dm_line), .dp_out(dp_out), .dp_oe(dp_oe), .dm_out(dm_out), .dm_oe(dm_oe),
		.sof_valid(sof_valid), .sof_frame(sof_frame), .setup_rx(setup_rx),
		.setup_ep(setup_ep), .full_speed_enable(fse), .engine_reset(ers),
		.engine_suspend(esus), .iso_limit(iso_limit), .irq(irq));

	usbc_line_host host_u (.mode(line_mode), .dp_out(dp_out), .dp_oe(dp_oe),
		.dm_out(dm_out), .dm_oe(dm_oe), .dp_line(dp_line), .dm_line(dm_line));

	// 20 MHz clock
	always #25 pclk = ~pclk;

	task automatic end_of_test();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// compare register read data
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t reg got %h exp %h", $time, got, exp);
		end
	endtask

	// compare block output pins
	task automatic chk_pin(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] t=%0t pin got %h exp %h", $time, got, exp);
		end
	endtask

	// one APB transfer; waits for pready, the watchdog bounds the wait;
	// one idle edge after it so that callers see settled outputs
	task automatic apb(input logic [15:0] idx, input logic wr, input logic [7:0] wd);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= {idx, `USBC_ALIGN};
		pwdata  <= {24'h000000, wd};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rdv = prdata;
		errv = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [15:0] idx, input logic [7:0] d);
		apb(idx, 1'b1, d);
	endtask

	task automatic rd_chk(input logic [15:0] idx, input logic [7:0] exp);
		apb(idx, 1'b0, 8'h00);
		chk_reg(rdv, {24'h000000, exp});
	endtask

	// single-cycle event strobes, and a line state held for a number of cycles
	task automatic sof(input logic [10:0] f);
		@(posedge pclk);
		sof_valid <= 1'b1;
		sof_frame <= f;
		@(posedge pclk);
		sof_valid <= 1'b0;
	endtask

	task automatic setup(input logic [3:0] ep);
		@(posedge pclk);
		setup_rx <= 1'b1;
		setup_ep <= ep;
		@(posedge pclk);
		setup_rx <= 1'b0;
		repeat (8) @(posedge pclk);
	endtask

	task automatic line(input logic [1:0] m, input int cyc);
		line_mode <= m;
		repeat (cyc) @(posedge pclk);
	endtask

	// expected endpoint word after one command
	function automatic logic [7:0] ep_apply(input logic [7:0] v, input logic [7:0] c);
		logic [3:0] nib;
		nib = c[7] ? v[7:4] : v[3:0];
		if (!c[6])
			nib[1:0] = c[5:4];
		else if (!c[5])
			nib[2] = c[4];
		else
			nib[3] = c[4];
		return c[7] ? {nib, v[3:0]} : {v[7:4], nib};
	endfunction

	// expected isochronous limit {total, data}
	function automatic logic [21:0] iso_exp(input logic [1:0] code);
		case (code)
			2'h0: return {11'h3FF, 11'h3FF};
			2'h2: return {11'h1F8, 11'h1F0};
			default: return {11'h0F8, 11'h0F0};
		endcase
	endfunction

	// watchdog
	initial begin
		#1000000;
		num_errors++;
		end_of_test();
	end

	// main sequence
	initial begin
		presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = '0;
		pwdata = '0; sof_valid = 0; sof_frame = '0; setup_rx = 0; setup_ep = '0;
		line_mode = 2'h0; num_errors = 0; num_checks = 0; ep_v = 8'h00;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(`USBC_IDX_CFG, `USBC_CFG_RST);
		rd_chk(`USBC_IDX_CTL2, `USBC_CTL2_RST);
		chk_pin({28'h0, fse, ers, esus, irq}, 32'h4);
		wr(`USBC_IDX_CFG, 8'h80);
		chk_pin({29'h0, fse, ers, esus}, 32'h4);
		wr(`USBC_IDX_CFG, 8'hFF);
		rd_chk(`USBC_IDX_CFG, 8'hFC);
		chk_pin({25'h0, fse, ers, esus, dp_oe, dm_oe, dp_out, dm_out}, 32'h7D);
		chk_pin({30'h0, dp_line, dm_line}, 32'h1);
		wr(`USBC_IDX_CFG, 8'h80);
		chk_pin({28'h0, dp_oe, dm_oe, esus, ers}, 32'h0);
		apb(16'h7F00, 1'b0, 8'h00);
		chk_pin({31'h0, errv}, 32'h1);
		chk_reg(rdv, 32'h0);
		$display("registers and unmapped access done");
		for (int c = 0; c < 4; c++) begin
			wr(`USBC_IDX_CTL2, c[7:0]);
			rd_chk(`USBC_IDX_CTL2, c[7:0]);
			chk_pin({10'h0, iso_limit}, {10'h0, iso_exp(c[1:0])});
		end
		$display("isochronous limits done");
		sof(11'h7FA);
		rd_chk(`USBC_IDX_FRH, 8'h07);
		rd_chk(`USBC_IDX_FRL, 8'hFA);
		wr(`USBC_IDX_CFG, 8'h90);
		sof(11'h001);
		rd_chk(`USBC_IDX_FRH, 8'h08);
		sof(11'h400);
		sof(11'h000);
		rd_chk(`USBC_IDX_FRH, 8'h10);
		wr(`USBC_IDX_CFG, 8'hB0);
		rd_chk(`USBC_IDX_FRL, 8'h00);
		rd_chk(`USBC_IDX_FRH, 8'h10);
		wr(`USBC_IDX_CFG, 8'h80);
		rd_chk(`USBC_IDX_FRH, 8'h00);
		$display("frame count done");
		wr(`USBC_IDX_IEN, 8'h01);
		line(2'h1, 40);
		line(2'h0, 6);
		rd_chk(`USBC_IDX_IST, 8'h00);
		line(2'h1, 70);
		rd_chk(`USBC_IDX_CFG, 8'h81);
		chk_pin({31'h0, irq}, 32'h0);
		line(2'h0, 6);
		rd_chk(`USBC_IDX_IST, 8'h02);
		wr(`USBC_IDX_IEN, 8'h03);
		chk_pin({31'h0, irq}, 32'h1);
		wr(`USBC_IDX_ICL, 8'h02);
		rd_chk(`USBC_IDX_IST, 8'h00);
		chk_pin({31'h0, irq}, 32'h0);
		line(2'h1, 70);
		chk_pin({31'h0, irq}, 32'h1);
		line(2'h0, 6);
		wr(`USBC_IDX_ICL, 8'h02);
		rd_chk(`USBC_IDX_IST, 8'h00);
		$display("bus reset done");
		wr(`USBC_IDX_CFG, 8'h88);
		line(2'h2, 10);
		rd_chk(`USBC_IDX_CFG, 8'h8A);
		rd_chk(`USBC_IDX_IST, 8'h01);
		chk_pin({31'h0, irq}, 32'h1);
		line(2'h0, 2);
		wr(`USBC_IDX_CFG, 8'h80);
		wr(`USBC_IDX_ICL, 8'h01);
		rd_chk(`USBC_IDX_CFG, 8'h80);
		chk_pin({31'h0, irq}, 32'h0);
		$display("resume done");
		wr(`USBC_IDX_EPS, 8'h03);
		for (int d = 0; d < 2; d++) begin
			for (int c = 0; c < 8; c++) begin
				logic [7:0] cmd;
				cmd = {d[0], c[2:0], 4'h0} | 8'h03;
				wr(`USBC_IDX_CMD, cmd);
				ep_v = ep_apply(ep_v, cmd);
				rd_chk(`USBC_IDX_EPV, ep_v);
			end
		end
		rd_chk(`USBC_IDX_CMD, 8'hF3);
		wr(`USBC_IDX_EPS, 8'h06);
		rd_chk(`USBC_IDX_EPV, 8'h00);
		wr(`USBC_IDX_CMD, 8'hA6);
		rd_chk(`USBC_IDX_EPV, 8'h20);
		$display("endpoint commands done");
		wr(`USBC_IDX_CMD, 8'h16);
		rd_chk(`USBC_IDX_EPV, 8'h21);
		wr(`USBC_IDX_CTL2, 8'h00);
		setup(4'h6);
		rd_chk(`USBC_IDX_EPV, 8'h21);
		wr(`USBC_IDX_CTL2, 8'h04);
		setup(4'h6);
		rd_chk(`USBC_IDX_EPV, 8'h33);
		$display("busy on setup done");
		end_of_test();
	end

endmodule // usbc_engine_cfg_bench

`default_nettype wire
